// file: rtl/tccw_pkg.sv
// Purpose: constants and carriers of the timer capture/compare back end
// Assumes: one 32-bit word per register
// Notes:   flag bits clear by writing one
package tccw_pkg;
   // register byte offsets
   localparam logic [7:0] TCCW_OFF_CTRL   = 8'h00;
   localparam logic [7:0] TCCW_OFF_CMD    = 8'h04;
   localparam logic [7:0] TCCW_OFF_FLAGS  = 8'h08;
   localparam logic [7:0] TCCW_OFF_CNT    = 8'h0c;
   localparam logic [7:0] TCCW_OFF_PER    = 8'h10;
   localparam logic [7:0] TCCW_OFF_PERIOD_BUFFER = 8'h14;
   localparam logic [7:0] TCCW_OFF_CC     = 8'h20;
   localparam logic [7:0] TCCW_OFF_CCBUF  = 8'h30;
   // command bit positions
   localparam int TCCW_CMD_UPDATE  = 0;
   localparam int TCCW_CMD_RESTART = 1;
   localparam int TCCW_CMD_RESET   = 2;
   // flags register bit positions
   localparam int TCCW_FLG_WRAP   = 0;
   localparam int TCCW_FLG_ERR    = 1;
   localparam int TCCW_FLG_CH     = 2;
   localparam int TCCW_FLG_BV     = 6;
   localparam int TCCW_FLG_PERBV  = 10;
   localparam int TCCW_FLG_WAVE   = 12;
   // waveform modes
   localparam logic [2:0] TCCW_WG_NORMAL = 3'h0;
   localparam logic [2:0] TCCW_WG_FRQ    = 3'h1;
   localparam logic [2:0] TCCW_WG_SS     = 3'h3;
   localparam logic [2:0] TCCW_WG_DS_T   = 3'h5;
   localparam logic [2:0] TCCW_WG_DS_TB  = 3'h6;
   localparam logic [2:0] TCCW_WG_DS_B   = 3'h7;
   // event actions
   localparam logic [2:0] TCCW_EA_OFF     = 3'h0;
   localparam logic [2:0] TCCW_EA_CAPT    = 3'h1;
   localparam logic [2:0] TCCW_EA_RESTART = 3'h4;
   localparam logic [2:0] TCCW_EA_FRQCAP  = 3'h5;
   localparam logic [2:0] TCCW_EA_PW      = 3'h6;
   // reset values
   localparam logic [31:0] TCCW_CTRL_RST = 32'h0000_0000;
   localparam logic [15:0] TCCW_CNT_RST  = 16'h0000;
   localparam logic [15:0] TCCW_PER_RST  = 16'hffff;
   localparam logic [15:0] TCCW_CC_RST   = 16'h0000;

   typedef struct packed {
      logic [13:0] rsvd;
      logic        lock;
      logic        run;
      logic [3:0]  out_en;
      logic [3:0]  ch_en;
      logic        event_delay_bit;
      logic [2:0]  evact;
      logic        pad;
      logic [2:0]  wg;
   } tccw_ctrl_s;

   typedef struct packed {
      logic       err;
      logic [3:0] ch;
      logic       wrap;
   } tccw_evt_s;
endpackage : tccw_pkg

// file: rtl/tccw_top.sv
// Purpose: capture/compare and waveform back end of a 16-bit timer
// Assumes: count_tick is the timer clock pulse
// Notes:   AHB-Lite slave, zero wait states, always OKAY
// Notes on behaviour
// - pulse width: fall captures, rise restarts
// - cascaded upper timer uses delayed capture event
// - full channel: drop stamp, set error flag
// - compare match sets channel flag and event
// - buffered compare copied only at update
// - pin override needs mode, no action, enable
// - pin invert inverts the driven wave
// - toggle mode: channel a sets period, toggles
// - toggle rate: clock over 2N(value+1)
// - single slope: set on match, clear top
// - dual slope: set bottom, clear up, set down
// - four channels pins 0-3, two pins 4-5
// - wrap, per-channel and error interrupt flags
// - every flag condition also emits an event
// - wrap flag is dma request, counter/period ack
// - channel flag cleared by dma value access
// - update command acts as update unless locked
// - restart clears counter, direction, outputs
// - reset command only while timer is off
// - event delay bit delays input one cycle
// - channel enable gates captures per channel
// - buffer valid: compare set on write, cleared update; capture set on capture while channel flag set, cleared read
`timescale 1ns/10ps
module tccw_top #(
   parameter bit FOUR_CH = 1'b1
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic                  hreadyout,
   output logic                  hresp,
   output logic [31:0]           hrdata,
   input  wire logic             dma_active,
   input  wire logic             count_tick,
   input  wire logic [3:0]       ev_strobe,
   input  wire logic [3:0]       ev_rising,
   input  wire logic [7:0]       port_out_reg,
   input  wire logic [7:0]       pin_dir,
   input  wire logic [7:0]       pin_invert,
   output logic [7:0]            pin_out,
   output logic [7:0]            pin_oe,
   output tccw_pkg::tccw_evt_s   evt_out,
   output tccw_pkg::tccw_evt_s   dma_req
);
   import tccw_pkg::*;

   tccw_ctrl_s        ctrl_r;
   logic [15:0]       cnt_r;
   logic [15:0]       per_r;
   logic [15:0]       period_buffer_r;
   logic              perbv_r;
   logic              dir_r;
   logic              wrapf_r;
   logic              errf_r;
   logic              wr_pend_r;
   logic [7:0]        wr_addr_r;
   logic [3:0]        ev_d_r;
   logic [3:0]        rise_d_r;
   logic [31:0]       rdata_nxt;
   logic [3:0][15:0]  cc_w;
   logic [3:0][15:0]  ccbuf_w;
   logic [3:0]        bv_w;
   logic [3:0]        chf_w;
   logic [3:0]        wave_w;
   logic [3:0]        ch_ev;
   logic [3:0]        cap_err;

   logic acc, rd, mapped, wr_map;
   assign acc    = hsel & htrans[1] & hready;
   assign mapped = (haddr[31:8] == 24'h00_0000);
   assign rd     = acc & ~hwrite & mapped;
   assign wr_map = wr_pend_r;

   logic wr_ctrl, wr_cmd, wr_flags, wr_cnt, wr_per, wr_period_buffer;
   assign wr_ctrl   = wr_map & (wr_addr_r == TCCW_OFF_CTRL);
   assign wr_cmd    = wr_map & (wr_addr_r == TCCW_OFF_CMD);
   assign wr_flags  = wr_map & (wr_addr_r == TCCW_OFF_FLAGS);
   assign wr_cnt    = wr_map & (wr_addr_r == TCCW_OFF_CNT);
   assign wr_per    = wr_map & (wr_addr_r == TCCW_OFF_PER);
   assign wr_period_buffer = wr_map & (wr_addr_r == TCCW_OFF_PERIOD_BUFFER);

   // dma write to counter or period side acknowledges wrap request
   logic dma_wrap_ack;
   assign dma_wrap_ack = acc & hwrite & mapped & dma_active &
      ((haddr[7:0] == TCCW_OFF_CNT) | (haddr[7:0] == TCCW_OFF_PER) |
       (haddr[7:0] == TCCW_OFF_PERIOD_BUFFER));

   logic upd, restart, soft_rst, cmd_restart;
   assign cmd_restart = wr_cmd & hwdata[TCCW_CMD_RESTART];
   assign soft_rst = wr_cmd & hwdata[TCCW_CMD_RESET] & ~ctrl_r.run;

   logic [3:0] ev_use, rise_use;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ev_d_r   <= 4'h0;
         rise_d_r <= 4'h0;
      end else begin
         ev_d_r   <= ev_strobe;
         rise_d_r <= ev_rising;
      end
   end
   assign ev_use   = ctrl_r.event_delay_bit ? ev_d_r : ev_strobe;
   assign rise_use = ctrl_r.event_delay_bit ? rise_d_r : ev_rising;

   logic capture_mode;
   logic [3:0] ev_en;
   logic [3:0] cap_ev;
   assign capture_mode = (ctrl_r.evact == TCCW_EA_CAPT) |
      (ctrl_r.evact == TCCW_EA_FRQCAP) | (ctrl_r.evact == TCCW_EA_PW);
   assign ev_en = ev_use & ctrl_r.ch_en;
   always_comb begin
      case (ctrl_r.evact)
         TCCW_EA_CAPT:   cap_ev = ev_en;
         TCCW_EA_FRQCAP: cap_ev = ev_en & rise_use;
         TCCW_EA_PW:     cap_ev = ev_en & ~rise_use;
         default:        cap_ev = 4'h0;
      endcase
   end
   assign restart = cmd_restart |
      ((ctrl_r.evact == TCCW_EA_RESTART) & (|ev_use)) |
      ((ctrl_r.evact == TCCW_EA_FRQCAP) & (|(ev_en & rise_use))) |
      ((ctrl_r.evact == TCCW_EA_PW) & (|(ev_en & rise_use)));

   logic        tick, dual, at_top, at_bot;
   logic [15:0] top;
   assign tick   = ctrl_r.run & count_tick;
   assign dual   = ctrl_r.wg[2];
   assign top    = (ctrl_r.wg == TCCW_WG_FRQ) ? cc_w[0] : per_r;
   assign at_top = (cnt_r >= top);
   assign at_bot = (cnt_r == 16'h0000);

   logic top_ev, bot_ev, wrap_ev;
   assign top_ev = tick & at_top & (~dual | ~dir_r);
   // single slope reaches bottom on the wrap from top
   assign bot_ev = tick & (dual ? (at_bot & dir_r) : at_top);
   always_comb begin
      case (ctrl_r.wg)
         TCCW_WG_SS:    wrap_ev = bot_ev;
         TCCW_WG_DS_T:  wrap_ev = top_ev;
         TCCW_WG_DS_TB: wrap_ev = top_ev | bot_ev;
         TCCW_WG_DS_B:  wrap_ev = bot_ev;
         default:       wrap_ev = top_ev;
      endcase
   end
   assign upd = ((ctrl_r.wg == TCCW_WG_NORMAL) |
                 (ctrl_r.wg == TCCW_WG_FRQ) ? top_ev : bot_ev) |
      (wr_cmd & hwdata[TCCW_CMD_UPDATE] & ~ctrl_r.lock);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= TCCW_CNT_RST;
         dir_r <= 1'b0;
      end else if (soft_rst | restart) begin
         cnt_r <= TCCW_CNT_RST;
         dir_r <= 1'b0;
      end else if (wr_cnt) begin
         cnt_r <= hwdata[15:0];
      end else if (tick) begin
         if (dual) begin
            if (!dir_r && at_top) begin
               dir_r <= 1'b1;
               cnt_r <= cnt_r - 16'h0001;
            end else if (dir_r && at_bot) begin
               dir_r <= 1'b0;
               cnt_r <= cnt_r + 16'h0001;
            end else if (dir_r) begin
               cnt_r <= cnt_r - 16'h0001;
            end else begin
               cnt_r <= cnt_r + 16'h0001;
            end
         end else if (at_top) begin
            cnt_r <= TCCW_CNT_RST;
         end else begin
            cnt_r <= cnt_r + 16'h0001;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         per_r    <= TCCW_PER_RST;
         period_buffer_r <= TCCW_PER_RST;
         perbv_r  <= 1'b0;
      end else if (soft_rst) begin
         per_r    <= TCCW_PER_RST;
         period_buffer_r <= TCCW_PER_RST;
         perbv_r  <= 1'b0;
      end else begin
         if (upd && perbv_r) begin
            per_r   <= period_buffer_r;
            perbv_r <= 1'b0;
         end
         if (wr_per) begin
            per_r <= hwdata[15:0];
         end
         if (wr_period_buffer) begin
            period_buffer_r <= hwdata[15:0];
            perbv_r  <= 1'b1;
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_ch
         localparam logic [1:0] IDX = 2'(gi);
         logic [15:0] cc_r, buf_r;
         logic        bv_r, chf_r, wave_r, match, cc_rd, dma_cc;
         logic        dma_buf, wr_cc, wr_buf, take, w1c;
         assign match = tick & ~capture_mode & (cnt_r == cc_r);
         assign cc_rd = rd & (haddr[7:4] == TCCW_OFF_CC[7:4]) &
            (haddr[3:2] == IDX);
         assign dma_cc = acc & mapped & dma_active &
            (haddr[7:4] == TCCW_OFF_CC[7:4]) & (haddr[3:2] == IDX);
         assign dma_buf = acc & mapped & dma_active &
            (haddr[7:4] == TCCW_OFF_CCBUF[7:4]) & (haddr[3:2] == IDX);
         assign wr_cc = wr_map & (wr_addr_r[7:4] == TCCW_OFF_CC[7:4]) &
            (wr_addr_r[3:2] == IDX);
         assign wr_buf = wr_map &
            (wr_addr_r[7:4] == TCCW_OFF_CCBUF[7:4]) &
            (wr_addr_r[3:2] == IDX);
         // a read that drains the buffer frees room this cycle
         assign take = cap_ev[gi] &
            (~chf_r | ~bv_r | (cc_rd & bv_r));
         assign cap_err[gi] = cap_ev[gi] & ~take;
         assign ch_ev[gi] = match | take;
         assign w1c = wr_flags & hwdata[TCCW_FLG_CH + gi];

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               cc_r  <= TCCW_CC_RST;
               buf_r <= TCCW_CC_RST;
               bv_r  <= 1'b0;
               chf_r <= 1'b0;
            end else if (soft_rst) begin
               cc_r  <= TCCW_CC_RST;
               buf_r <= TCCW_CC_RST;
               bv_r  <= 1'b0;
               chf_r <= 1'b0;
            end else begin
               if (w1c || (capture_mode && dma_cc && !bv_r) ||
                   (!capture_mode && dma_buf)) begin
                  chf_r <= 1'b0;
               end
               if (capture_mode) begin
                  if (cc_rd && bv_r) begin
                     cc_r <= buf_r;
                     bv_r <= 1'b0;
                  end
                  if (take && !chf_r) begin
                     cc_r  <= cnt_r;
                     chf_r <= 1'b1;
                  end else if (take) begin
                     buf_r <= cnt_r;
                     bv_r  <= 1'b1;
                     chf_r <= 1'b1;
                  end
               end else begin
                  if (upd && bv_r) begin
                     cc_r <= buf_r;
                     bv_r <= 1'b0;
                  end
                  if (wr_buf) begin
                     buf_r <= hwdata[15:0];
                     bv_r  <= 1'b1;
                  end
                  if (match) begin
                     chf_r <= 1'b1;
                  end
               end
               if (wr_cc) begin
                  cc_r <= hwdata[15:0];
               end
            end
         end

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               wave_r <= 1'b0;
            end else if (soft_rst || restart) begin
               wave_r <= 1'b0;
            end else begin
               case (ctrl_r.wg)
                  TCCW_WG_FRQ: begin
                     if (gi == 0 && match) begin
                        wave_r <= ~wave_r;
                     end
                  end
                  TCCW_WG_SS: begin
                     if (tick && at_top) begin
                        wave_r <= 1'b0;
                     end else if (match) begin
                        wave_r <= 1'b1;
                     end
                  end
                  TCCW_WG_DS_T, TCCW_WG_DS_TB, TCCW_WG_DS_B: begin
                     if (match) begin
                        wave_r <= dir_r;
                     end else if (tick && at_bot) begin
                        wave_r <= 1'b1;
                     end
                  end
                  default: ;
               endcase
            end
         end

         assign cc_w[gi]    = cc_r;
         assign ccbuf_w[gi] = buf_r;
         assign bv_w[gi]    = bv_r;
         assign chf_w[gi]   = chf_r;
         assign wave_w[gi]  = wave_r;
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r  <= TCCW_CTRL_RST;
         wrapf_r <= 1'b0;
         errf_r  <= 1'b0;
      end else if (soft_rst) begin
         ctrl_r  <= TCCW_CTRL_RST;
         wrapf_r <= 1'b0;
         errf_r  <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_r      <= hwdata;
            ctrl_r.rsvd <= 14'h0000;
            ctrl_r.pad  <= 1'b0;
         end
         if ((wr_flags && hwdata[TCCW_FLG_WRAP]) || dma_wrap_ack) begin
            wrapf_r <= 1'b0;
         end
         if (wrap_ev) begin
            wrapf_r <= 1'b1;
         end
         if (wr_flags && hwdata[TCCW_FLG_ERR]) begin
            errf_r <= 1'b0;
         end
         if (|cap_err) begin
            errf_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         evt_out <= '0;
         dma_req <= '0;
      end else begin
         evt_out.wrap <= wrap_ev;
         evt_out.ch   <= ch_ev;
         evt_out.err  <= |cap_err;
         dma_req.wrap <= wrapf_r;
         dma_req.ch   <= chf_w;
         dma_req.err  <= 1'b0;
      end
   end

   genvar gp;
   generate
      for (gp = 0; gp < 8; gp++) begin : g_pin
         localparam int CH = FOUR_CH ? gp : gp - 4;
         localparam bit HAS = FOUR_CH ? (gp < 4) : (gp == 4 || gp == 5);
         logic ovr;
         logic wv;
         if (HAS) begin : g_on
            assign wv  = wave_w[CH];
            assign ovr = (ctrl_r.wg != TCCW_WG_NORMAL) &
               (ctrl_r.evact == TCCW_EA_OFF) & ctrl_r.out_en[CH] &
               pin_dir[gp];
         end else begin : g_off
            assign wv  = 1'b0;
            assign ovr = 1'b0;
         end
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               pin_out[gp] <= 1'b0;
               pin_oe[gp]  <= 1'b0;
            end else begin
               pin_out[gp] <= (ovr ? wv : port_out_reg[gp]) ^
                  pin_invert[gp];
               pin_oe[gp]  <= pin_dir[gp];
            end
         end
      end
   endgenerate

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (haddr[7:4] == TCCW_OFF_CC[7:4]) begin
         rdata_nxt[15:0] = cc_w[haddr[3:2]];
      end else if (haddr[7:4] == TCCW_OFF_CCBUF[7:4]) begin
         rdata_nxt[15:0] = ccbuf_w[haddr[3:2]];
      end else begin
         case (haddr[7:0])
            TCCW_OFF_CTRL:   rdata_nxt = ctrl_r;
            TCCW_OFF_FLAGS: begin
               rdata_nxt[TCCW_FLG_WRAP]      = wrapf_r;
               rdata_nxt[TCCW_FLG_ERR]       = errf_r;
               rdata_nxt[TCCW_FLG_CH +: 4]   = chf_w;
               rdata_nxt[TCCW_FLG_BV +: 4]   = bv_w;
               rdata_nxt[TCCW_FLG_PERBV]     = perbv_r;
               rdata_nxt[TCCW_FLG_WAVE +: 4] = wave_w;
            end
            TCCW_OFF_CNT:    rdata_nxt[15:0] = cnt_r;
            TCCW_OFF_PER:    rdata_nxt[15:0] = per_r;
            TCCW_OFF_PERIOD_BUFFER: rdata_nxt[15:0] = period_buffer_r;
            default: ;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         wr_pend_r <= acc & hwrite & mapped;
         wr_addr_r <= haddr[7:0];
         hrdata    <= rd ? rdata_nxt : 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end
endmodule : tccw_top

// file: dv/tccw_top_properties.sv
// Purpose: port-level checks of tccw_top
// Assumes: zero wait-state bus
// Notes:   bound into tccw_top
`timescale 1ns/10ps
module tccw_top_properties #(
   parameter bit FOUR_CH = 1'b1
) (
   input wire logic                hclk,
   input wire logic                hresetn,
   input wire logic                hsel,
   input wire logic [31:0]         haddr,
   input wire logic [1:0]          htrans,
   input wire logic                hwrite,
   input wire logic                hready,
   input wire logic                hreadyout,
   input wire logic                hresp,
   input wire logic [31:0]         hrdata,
   input wire logic                dma_active,
   input wire logic                count_tick,
   input wire logic [7:0]          port_out_reg,
   input wire logic [7:0]          pin_dir,
   input wire logic [7:0]          pin_invert,
   input wire logic [7:0]          pin_out,
   input wire logic [7:0]          pin_oe,
   input wire tccw_pkg::tccw_evt_s evt_out,
   input wire tccw_pkg::tccw_evt_s dma_req
);
   import tccw_pkg::*;
   logic       rd_ph;
   logic [3:0] fr_pin;
   logic [3:0] fr_exp;
   logic       dma_cnt;
   // pins no channel overrides
   assign fr_pin = FOUR_CH ? pin_out[7:4] : pin_out[3:0];
   assign fr_exp = FOUR_CH ? port_out_reg[7:4] ^ pin_invert[7:4]
                           : port_out_reg[3:0] ^ pin_invert[3:0];
   assign dma_cnt = hsel & htrans[1] & hready & hwrite & dma_active
                    & (haddr == {24'h00_0000, TCCW_OFF_CNT});
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) rd_ph <= 1'b0;
      else rd_ph <= hsel & htrans[1] & hready & ~hwrite;
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("hresp not okay");
   property p_ready; $past(hresetn) |-> hreadyout; endproperty
   a_ready: assert property (p_ready) else $error("hreadyout low");
   property p_rdata; !rd_ph |-> hrdata == 32'h0000_0000; endproperty
   a_rdata: assert property (p_rdata) else $error("hrdata outside phase");
   property p_oe; $past(hresetn) |-> pin_oe == $past(pin_dir); endproperty
   a_oe: assert property (p_oe) else $error("pin_oe wrong");
   property p_free; $past(hresetn) |-> fr_pin == $past(fr_exp); endproperty
   a_free: assert property (p_free) else $error("free pin wrong");
   property p_dir;
      $past(hresetn) && !$past(pin_dir[0]) |->
         pin_out[0] == $past(port_out_reg[0] ^ pin_invert[0]);
   endproperty
   a_dir: assert property (p_dir) else $error("input pin driven");
   property p_err_dma; dma_req.err == 1'b0; endproperty
   a_err_dma: assert property (p_err_dma) else $error("err dma");
   property p_evt_wrap; evt_out.wrap |-> ##[0:2] dma_req.wrap; endproperty
   a_evt_wrap: assert property (p_evt_wrap) else $error("wrap");
   property p_evt_ch; evt_out.ch[0] |-> ##[0:2] dma_req.ch[0]; endproperty
   a_evt_ch: assert property (p_evt_ch) else $error("chan evt");
   property p_wrap_ack;
      dma_cnt ##0 (!count_tick)[*4] |=> !dma_req.wrap;
   endproperty
   a_wrap_ack: assert property (p_wrap_ack) else $error("no ack");
   c_err: cover property (evt_out.err);
   c_ch: cover property (evt_out.ch[0]);
   c_ack: cover property (dma_cnt ##0 (!count_tick)[*4]);
endmodule : tccw_top_properties

bind tccw_top tccw_top_properties #(.FOUR_CH(FOUR_CH)) tccw_top_properties_i (
   .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
   .hresp, .hrdata, .dma_active, .count_tick, .port_out_reg, .pin_dir,
   .pin_invert, .pin_out, .pin_oe, .evt_out, .dma_req);

// file: dv/tccw_far_model.sv
// Purpose: event network, port pins, timer tick
// Assumes: pin source senses both edges, prescale of one
// Notes:   idle qualifier flips so a stale level is never trusted
`timescale 1ns/10ps
module tccw_far_model (
   input  wire logic  hclk,
   output logic       count_tick,
   output logic [3:0] ev_strobe,
   output logic [3:0] ev_rising,
   output logic [7:0] port_out_reg,
   output logic [7:0] pin_dir,
   output logic [7:0] pin_invert
);
   initial begin
      count_tick = 1'b0;
      ev_strobe = 4'h0;
      ev_rising = 4'h0;
      port_out_reg = 8'h00;
      pin_dir = 8'h00;
      pin_invert = 8'h00;
   end
   task automatic ev(input logic [3:0] s, input logic r);
      @(posedge hclk);
      ev_strobe <= s;
      ev_rising <= {4{r}};
      @(posedge hclk);
      ev_strobe <= 4'h0;
      ev_rising <= ~ev_rising;
   endtask : ev
   task automatic pins(input logic [7:0] o, d, i);
      @(posedge hclk);
      port_out_reg <= o;
      pin_dir <= d;
      pin_invert <= i;
   endtask : pins
   task automatic tick(input logic b);
      @(posedge hclk);
      count_tick <= b;
   endtask : tick
endmodule : tccw_far_model

// file: dv/tccw_tb_top.sv
// Purpose: directed bench of tccw_top
// Assumes: tick every cycle when enabled
// Notes:   pin 0 carries channel A
`timescale 1ns/10ps
module tccw_tb_top;
   import tccw_pkg::*;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic        dma_active = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        count_tick;
   logic [3:0]  ev_strobe;
   logic [3:0]  ev_rising;
   logic [7:0]  port_out_reg;
   logic [7:0]  pin_dir;
   logic [7:0]  pin_invert;
   logic [7:0]  pin_out;
   logic [7:0]  pin_oe;
   tccw_evt_s   evt_out;
   tccw_evt_s   dma_req;
   logic [31:0] q;
   int          n_fail = 0;
   int          checks_done = 0;
   int          hi;
   int          tg;
   always #5 hclk = ~hclk;
   tccw_top #(.FOUR_CH(1'b1)) tccw_top_i (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .dma_active, .count_tick, .ev_strobe, .ev_rising, .port_out_reg,
      .pin_dir, .pin_invert, .pin_out, .pin_oe, .evt_out, .dma_req);
   tccw_far_model tccw_far_model_i (.hclk, .count_tick, .ev_strobe,
      .ev_rising, .port_out_reg, .pin_dir, .pin_invert);
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   task automatic cmp(input logic [31:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic dma);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      dma_active <= dma;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      dma_active <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 1'b0);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
      bus(1'b0, a, 32'h0000_0000, 1'b0);
      cmp(q & m, e);
   endtask : rd
   task automatic cyc(input int n);
      repeat (n) @(negedge hclk);
   endtask : cyc
   // high samples and toggles of pin 0
   task automatic meas(input int n);
      logic p;
      hi = 0;
      tg = 0;
      @(negedge hclk);
      p = pin_out[0];
      repeat (n) begin
         @(negedge hclk);
         hi += int'(pin_out[0] === 1'b1);
         tg += int'(pin_out[0] !== p);
         p = pin_out[0];
      end
   endtask : meas
   function automatic logic [31:0] ctl(input logic [2:0] wg, ea,
                                       input logic run, lock);
      tccw_ctrl_s c;
      c = '0;
      c.wg = wg;
      c.evact = ea;
      c.ch_en = 4'h1;
      c.out_en = 4'h1;
      c.run = run;
      c.lock = lock;
      return c;
   endfunction : ctl
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(TCCW_OFF_CTRL, '1, TCCW_CTRL_RST);
      rd(TCCW_OFF_PER, '1, 32'h0000_ffff);
      rd(8'h80, '1, 32'h0000_0000);
      tccw_far_model_i.pins(8'ha5, 8'h01, 8'h00);
      wr(TCCW_OFF_CC, 32'h0000_0002);
      wr(TCCW_OFF_CTRL, ctl(TCCW_WG_FRQ, TCCW_EA_OFF, 1'b1, 1'b0));
      tccw_far_model_i.tick(1'b1);
      cyc(20);
      meas(24);
      cmp(32'(tg), 32'h0000_0008);
      rd(TCCW_OFF_FLAGS, 32'h0000_0005, 32'h0000_0005);
      tccw_far_model_i.tick(1'b0);
      bus(1'b1, TCCW_OFF_CNT, 32'h0000_0000, 1'b1);
      bus(1'b1, TCCW_OFF_CCBUF, 32'h0000_0002, 1'b1);
      rd(TCCW_OFF_FLAGS, 32'h0000_0005, 32'h0000_0000);
      wr(TCCW_OFF_CTRL, ctl(TCCW_WG_FRQ, TCCW_EA_OFF, 1'b0, 1'b0));
      wr(TCCW_OFF_CMD, 32'h0000_0002);
      rd(TCCW_OFF_CNT, '1, 32'h0000_0000);
      cyc(3);
      cmp(32'(pin_out[0]), 32'h0000_0000);
      tccw_far_model_i.pins(8'ha5, 8'h01, 8'h01);
      cyc(3);
      cmp(32'(pin_out[0]), 32'h0000_0001);
      tccw_far_model_i.pins(8'ha5, 8'h01, 8'h00);
      wr(TCCW_OFF_CCBUF + 8'h04, 32'h0000_0005);
      rd(TCCW_OFF_CC + 8'h04, '1, 32'h0000_0000);
      rd(TCCW_OFF_FLAGS, 32'h0000_0080, 32'h0000_0080);
      wr(TCCW_OFF_CMD, 32'h0000_0001);
      rd(TCCW_OFF_CC + 8'h04, '1, 32'h0000_0005);
      rd(TCCW_OFF_FLAGS, 32'h0000_0080, 32'h0000_0000);
      wr(TCCW_OFF_CTRL, ctl(TCCW_WG_FRQ, TCCW_EA_OFF, 1'b0, 1'b1));
      wr(TCCW_OFF_CCBUF + 8'h04, 32'h0000_0006);
      wr(TCCW_OFF_CMD, 32'h0000_0001);
      rd(TCCW_OFF_CC + 8'h04, '1, 32'h0000_0005);
      wr(TCCW_OFF_PER, 32'h0000_0007);
      wr(TCCW_OFF_CC, 32'h0000_0003);
      wr(TCCW_OFF_CTRL, ctl(TCCW_WG_SS, TCCW_EA_OFF, 1'b1, 1'b0));
      tccw_far_model_i.tick(1'b1);
      cyc(20);
      meas(16);
      cmp(32'(hi), 32'h0000_0008);
      wr(TCCW_OFF_CC, 32'h0000_0002);
      wr(TCCW_OFF_CTRL, ctl(TCCW_WG_DS_T, TCCW_EA_OFF, 1'b1, 1'b0));
      cyc(30);
      meas(28);
      cmp(32'(hi), 32'h0000_0008);
      wr(TCCW_OFF_CMD, 32'h0000_0004);
      rd(TCCW_OFF_PER, '1, 32'h0000_0007);
      tccw_far_model_i.tick(1'b0);
      wr(TCCW_OFF_CTRL, ctl(TCCW_WG_DS_T, TCCW_EA_OFF, 1'b0, 1'b0));
      wr(TCCW_OFF_CMD, 32'h0000_0004);
      rd(TCCW_OFF_PER, '1, 32'h0000_ffff);
      rd(TCCW_OFF_CTRL, '1, 32'h0000_0000);
      wr(TCCW_OFF_CTRL,
         ctl(TCCW_WG_NORMAL, TCCW_EA_PW, 1'b1, 1'b0) | 32'h0000_0080);
      wr(TCCW_OFF_CNT, 32'h0000_0055);
      tccw_far_model_i.ev(4'h3, 1'b1);
      rd(TCCW_OFF_CNT, '1, 32'h0000_0000);
      wr(TCCW_OFF_CNT, 32'h0000_0012);
      repeat (3) tccw_far_model_i.ev(4'h3, 1'b0);
      rd(TCCW_OFF_FLAGS, 32'h0000_007f, 32'h0000_0046);
      rd(TCCW_OFF_CC, '1, 32'h0000_0012);
      cmp(32'(pin_out[0]), 32'h0000_0001);
      finish_test;
   end
   // span well above the directed run
   initial begin
      #50000;
      n_fail++;
      finish_test;
   end
endmodule : tccw_tb_top
